//--- src/sapc_defines.vh
// Purpose: shared constants of the converter control block
// Assumes: mclk at 10 MHz (100 ns period)
// Notes:   times in ns, cycle counts derived from the clock period
`ifndef SAPC_DEFINES_VH
`define SAPC_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAPC_CLK_PERIOD_NS   100
`define SAPC_T_CONV_NS       1600
// conversion split over the bit decisions; longest time rounds down
`define SAPC_CONV_CYCLES     (`SAPC_T_CONV_NS / `SAPC_CLK_PERIOD_NS)
`define SAPC_T_ACQ_NS        200
`define SAPC_T_WAKE_NS       350

// ----------------------------------------------------------------
// data layout and reset values
// ----------------------------------------------------------------
`define SAPC_RES_BITS        12
`define SAPC_RESULT_RESET    12'h000
`define SAPC_FIFO_DEPTH      16

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define SAPC_ST_IDLE         2'h0
`define SAPC_ST_CLEAR        2'h1
`define SAPC_ST_TRIAL        2'h2
`define SAPC_ST_LOAD         2'h3

`endif

//--- src/sapc_fifo.v
// Purpose: result fifo with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes:   full and empty come from an extra pointer bit
`include "sapc_defines.vh"

module sapc_fifo #(
    parameter WIDTH = `SAPC_RES_BITS,
    parameter DEPTH = `SAPC_FIFO_DEPTH,
    parameter AW    = 4
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            push;
    wire            pop;
    wire            empty;
    wire            full;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign push      = in_valid & ~full;
    assign pop       = out_ready & ~empty;

    // storage write, no reset needed for data words
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // pointers; head word is read combinationally from memory, not registered
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // head word follows read pointer (fall-through, no added cycle)
    always @* begin
        out_data = mem[rd_ptr[AW-1:0]];
    end
endmodule

//--- src/sapc_trial.v
// Purpose: successive-approximation bit-trial register
// Assumes: comparator answer valid on each step cycle
// Notes:   one bit decided per step, top bit first
`include "sapc_defines.vh"

module sapc_trial #(
    parameter BITS = `SAPC_RES_BITS
) (
    input  wire            mclk,
    input  wire            rst,
    input  wire            clear,
    input  wire            step,
    input  wire            comp_keep,
    output reg  [BITS-1:0] bit_trial_register,
    output reg  [BITS-1:0] bit_pointer,
    output wire            last_bit
);
    assign last_bit = bit_pointer[0];

    // ------------------------------------------------------------
    // per-bit trial decisions
    // ------------------------------------------------------------
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            bit_pointer <= {BITS{1'b0}};
        end else if (clear) begin
            bit_pointer <= {1'b1, {(BITS-1){1'b0}}}; // start at top bit
        end else if (step) begin
            bit_pointer <= bit_pointer >> 1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < BITS; i = i + 1) begin : g_bit
            // each bit: cleared, then takes the comparator answer on its step
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    bit_trial_register[i] <= 1'b0;
                end else if (clear) begin
                    bit_trial_register[i] <= 1'b0;
                end else if (step && bit_pointer[i]) begin
                    bit_trial_register[i] <= comp_keep;
                end
            end
        end
    endgenerate
endmodule

//--- src/sapc_control.v
// Purpose: control of a 12-bit sampling converter, parallel host port
// Assumes: host pins synchronous to mclk; comparator from analog side
// Notes:   results also queue in a fifo for a streaming consumer
//
// Contract
// - A conversion begins on the falling edge of conversion_start_n.
// - Start and read strobes are ignored while chip_select_n is high.
// - Data pins are driven only while read_n and chip_select_n are low.
// - busy_n is low during a conversion and high otherwise.
// - The bit-trial register is cleared before any bit decision.
// - Start edges during a conversion are ignored.
// - Bits are decided one at a time from the top bit down.
// - The finished word is copied into the output latches.
// - Twelve data pins, the highest carrying the top bit.
// - No conversion starts while power_down_n is low.
// - A full conversion takes 1.4 us (14 mclk cycles of busy) on the internal clock.
`include "sapc_defines.vh"

module sapc_control #(
    parameter BITS       = `SAPC_RES_BITS,
    parameter FIFO_DEPTH = `SAPC_FIFO_DEPTH
) (
    input  wire            mclk,
    input  wire            rst,
    input  wire            chip_select_n,
    input  wire            conversion_start_n,
    input  wire            read_n,
    input  wire            power_down_n,
    input  wire            comp_keep,
    output wire            comp_trial_valid,
    output wire [BITS-1:0] comp_trial_word,
    output reg             busy_n,
    output wire [BITS-1:0] data_out,
    output wire [BITS-1:0] data_oe,
    output wire [BITS-1:0] stream_data,
    output wire            stream_valid,
    input  wire            stream_ready,
    output wire            result_dropped
);
    // ------------------------------------------------------------
    // timing derived from the clock
    // ------------------------------------------------------------
    // cycles per bit decision, rounded down from the conversion time
    // integer helpers keep the divisions exact before the cut to 8 bits
    localparam integer CONV_INT = `SAPC_CONV_CYCLES;
    localparam integer STEP_INT = (CONV_INT / BITS) < 1 ?
                                  1 : (CONV_INT / BITS);
    localparam [7:0] CONV_CYC = CONV_INT[7:0];
    localparam [7:0] STEP_CYC = STEP_INT[7:0];
    localparam [1:0] ST_IDLE  = `SAPC_ST_IDLE;
    localparam [1:0] ST_CLEAR = `SAPC_ST_CLEAR;
    localparam [1:0] ST_TRIAL = `SAPC_ST_TRIAL;
    localparam [1:0] ST_LOAD  = `SAPC_ST_LOAD;

    reg  [1:0]      state;
    reg  [1:0]      next_state;
    reg             start_prev;
    reg  [7:0]      step_cnt;
    reg  [BITS-1:0] out_latch;
    reg             drop_flag;
    wire            start_fall;
    wire            step;
    wire            clear;
    wire            last_bit;
    wire            fifo_ready;
    wire [BITS-1:0] trial_word;
    wire [BITS-1:0] bit_pointer;

    // ------------------------------------------------------------
    // start recognition
    // ------------------------------------------------------------
    // edge seen only while selected, so a deselected toggle is lost
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_prev <= 1'b1;
        end else begin
            start_prev <= conversion_start_n | chip_select_n;
        end
    end

    assign start_fall = start_prev & ~conversion_start_n &
                        ~chip_select_n;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // power-down blocks the start entirely
                if (start_fall && power_down_n) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                next_state = ST_TRIAL;
            end
            ST_TRIAL: begin
                // further start edges have no effect here
                if (step && last_bit) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // per-bit pacing; 16 conversion cycles over twelve decisions rounds down to one per cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            step_cnt <= 8'h00;
        end else if (state != ST_TRIAL || step) begin
            step_cnt <= 8'h00;
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    assign step  = (state == ST_TRIAL) &&
                   (step_cnt == STEP_CYC - 8'h01);
    assign clear = (state == ST_CLEAR);

    sapc_trial #(
        .BITS (BITS)
    ) u_trial (
        .mclk               (mclk),
        .rst                (rst),
        .clear              (clear),
        .step               (step),
        .comp_keep          (comp_keep),
        .bit_trial_register (trial_word),
        .bit_pointer        (bit_pointer),
        .last_bit           (last_bit)
    );

    // comparator sees current word with the bit under test set
    assign comp_trial_word  = trial_word | bit_pointer;
    assign comp_trial_valid = (state == ST_TRIAL);

    // ------------------------------------------------------------
    // output latches and busy
    // ------------------------------------------------------------
    // latch loads at the end of ST_LOAD; busy rises on the same edge, so a host
    // capturing on the busy rising edge sees the new word
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_latch <= `SAPC_RESULT_RESET;
        end else if (state == ST_LOAD) begin
            out_latch <= trial_word;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_n <= 1'b1;
        end else begin
            busy_n <= (next_state == ST_IDLE);
        end
    end

    // pin k carries latch bit k, top pin is the top bit
    assign data_out = out_latch;
    assign data_oe  = {BITS{~read_n & ~chip_select_n}};

    // ------------------------------------------------------------
    // result stream
    // ------------------------------------------------------------
    // a full fifo cannot stall the analog conversion, so the word is
    // dropped and flagged; the parallel latch still gets it
    sapc_fifo #(
        .WIDTH (BITS),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (trial_word),
        .in_valid  (state == ST_LOAD),
        .in_ready  (fifo_ready),
        .out_data  (stream_data),
        .out_valid (stream_valid),
        .out_ready (stream_ready)
    );

    // sticky until reset
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            drop_flag <= 1'b0;
        end else if (state == ST_LOAD && !fifo_ready) begin
            drop_flag <= 1'b1;
        end
    end

    assign result_dropped = drop_flag;
endmodule

//--- tb/sapc_monitor.sv
// Purpose: port checker for the converter control block
// Assumes: one clock mclk, async active-high rst
// Notes:   bound to every sapc_control instance
module sapc_monitor #(
    parameter BITS = 12
) (
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            chip_select_n,
    input wire logic            conversion_start_n,
    input wire logic            read_n,
    input wire logic            power_down_n,
    input wire logic            comp_trial_valid,
    input wire logic [BITS-1:0] comp_trial_word,
    input wire logic            busy_n,
    input wire logic [BITS-1:0] data_out,
    input wire logic [BITS-1:0] data_oe,
    input wire logic [BITS-1:0] stream_data,
    input wire logic            stream_valid,
    input wire logic            stream_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic prev_hi;

    // previous start/select sample; high at reset so a held start counts
    always @(posedge mclk or posedge rst) begin
        if (rst)
            prev_hi <= 1'b1;
        else
            prev_hi <= conversion_start_n | chip_select_n;
    end

    chk_start_busy: assert property (
        prev_hi && !conversion_start_n && !chip_select_n && power_down_n
        && busy_n |=> !busy_n) else $error("start not taken");
    chk_select_gate: assert property (
        busy_n && chip_select_n |=> busy_n) else $error("start w/o select");
    chk_read_drive: assert property (
        data_oe == {BITS{!read_n && !chip_select_n}})
        else $error("data drive mismatch");
    chk_busy_span: assert property (
        $fell(busy_n) |-> !busy_n[*8] ##1 !busy_n[*6] ##1 busy_n)
        else $error("busy span wrong");
    chk_trial_first: assert property (
        $rose(comp_trial_valid) |->
        comp_trial_word == {1'b1, {(BITS-1){1'b0}}})
        else $error("first trial not top bit");
    chk_trial_run: assert property (
        $rose(comp_trial_valid) |-> comp_trial_valid[*8] ##1
        comp_trial_valid[*4] ##1 !comp_trial_valid)
        else $error("trial count wrong");
    chk_latch_hold: assert property (
        !$stable(data_out) |-> $rose(busy_n)) else $error("latch off busy");
    chk_power_block: assert property (
        !power_down_n && busy_n |=> busy_n) else $error("start in power down");
    chk_stream_hold: assert property (
        stream_valid && !stream_ready |=> stream_valid && $stable(stream_data))
        else $error("stream word lost");
endmodule

bind sapc_control sapc_monitor #(.BITS(BITS)) u_mon (
    .mclk(mclk), .rst(rst), .chip_select_n(chip_select_n),
    .conversion_start_n(conversion_start_n), .read_n(read_n),
    .power_down_n(power_down_n), .comp_trial_valid(comp_trial_valid),
    .comp_trial_word(comp_trial_word), .busy_n(busy_n),
    .data_out(data_out), .data_oe(data_oe), .stream_data(stream_data),
    .stream_valid(stream_valid), .stream_ready(stream_ready));

//--- tb/sapc_comp_model.sv
// Purpose: comparator stand-in for the analog side of the converter
// Assumes: trial word valid while trial_valid is high
// Notes:   target is the input code the bench wants converted
module sapc_comp_model (
    input  wire logic        mclk,
    input  wire logic        trial_valid,
    input  wire logic [11:0] trial_word,
    input  wire logic [11:0] target,
    output logic             keep
);
    timeunit 1ns;
    timeprecision 100ps;
    logic junk = 1'b0;

    // outside trials the answer wanders, so a stray sample shows up
    always @(posedge mclk) junk <= ~junk;
    // keep the tested bit while the trial stays at or below target
    assign keep = trial_valid ? (trial_word <= target) : junk;
endmodule

//--- tb/test_sapc_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   fifo is stalled on purpose in one test
module test_sapc_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        chip_select_n = 1'b0;
    logic        conversion_start_n = 1'b1;
    logic        read_n = 1'b1;
    logic        power_down_n = 1'b1;
    logic        stream_ready = 1'b1;
    logic [11:0] target = 12'h000;
    wire         comp_keep, trial_valid, busy_n, stream_valid, dropped;
    wire  [11:0] trial_word, data_out, data_oe, stream_data;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n;

    sapc_control uut (.mclk(mclk), .rst(rst), .chip_select_n(chip_select_n),
        .conversion_start_n(conversion_start_n), .read_n(read_n),
        .power_down_n(power_down_n), .comp_keep(comp_keep),
        .comp_trial_valid(trial_valid), .comp_trial_word(trial_word),
        .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe),
        .stream_data(stream_data), .stream_valid(stream_valid),
        .stream_ready(stream_ready), .result_dropped(dropped));
    sapc_comp_model model (.mclk(mclk), .trial_valid(trial_valid),
        .trial_word(trial_word), .target(target), .keep(comp_keep));

    initial forever #50 mclk = ~mclk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // one conversion; glitch pulses start again mid-run
    task automatic conv(input logic [11:0] v, input bit glitch);
        target = v;
        conversion_start_n = 1'b0;
        tick(1);
        conversion_start_n = 1'b1;
        cmp_bit(busy_n, 1'b0);
        n = 0;
        while (busy_n !== 1'b1 && n < 40) begin
            if (glitch)
                conversion_start_n = (n != 3);
            tick(1);
            n++;
        end
        cmp_word(12'(n), 12'h00e);
        cmp_word(data_out, v);
        read_n = 1'b0;
        #1;
        cmp_word(data_oe, 12'hfff);
        cmp_bit(data_out[11], v[11]);
        read_n = 1'b1;
        tick(2);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_codes();
        logic [11:0] codes [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff,
                                   12'ha5c};
        foreach (codes[i]) conv(codes[i], 1'b0);
        $display("t_codes done");
    endtask
    task automatic t_gate();
        chip_select_n = 1'b1;
        conversion_start_n = 1'b0;
        read_n = 1'b0;
        tick(1);
        cmp_word(data_oe, 12'h000);
        tick(4);
        cmp_bit(busy_n, 1'b1);
        conversion_start_n = 1'b1;
        read_n = 1'b1;
        tick(1);
        chip_select_n = 1'b0;
        tick(1);
        $display("t_gate done");
    endtask
    task automatic t_power();
        power_down_n = 1'b0;
        conversion_start_n = 1'b0;
        tick(1);
        conversion_start_n = 1'b1;
        tick(4);
        cmp_bit(busy_n, 1'b1);
        power_down_n = 1'b1;
        tick(4);
        conv(12'h3c3, 1'b0);
        $display("t_power done");
    endtask
    // restart attempt must neither stretch nor spoil the result
    task automatic t_restart();
        conv(12'h5a5, 1'b1);
        $display("t_restart done");
    endtask
    // stalled consumer: 16 words fit, the 17th is dropped
    task automatic t_fifo();
        stream_ready = 1'b0;
        for (int i = 0; i < 17; i++) conv(12'(i * 37), 1'b0);
        cmp_bit(dropped, 1'b1);
        stream_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            cmp_bit(stream_valid, 1'b1);
            cmp_word(stream_data, 12'(i * 37));
            tick(1);
        end
        cmp_bit(stream_valid, 1'b0);
        $display("t_fifo done");
    endtask
    // reset after a finished conversion: outputs return to idle values, drop flag clears
    task automatic t_reset();
        conv(12'h6b2, 1'b0);
        rst = 1'b1;
        tick(2);
        cmp_word(data_out, 12'h000);
        cmp_bit(busy_n, 1'b1);
        cmp_bit(dropped, 1'b0);
        cmp_bit(stream_valid, 1'b0);
        rst = 1'b0;
        tick(2);
        conv(12'h19e, 1'b0);
        $display("t_reset done");
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        tick(20);
        rst = 1'b0;
        tick(2);
        t_codes();
        t_gate();
        t_power();
        t_restart();
        t_fifo();
        t_reset();
        stop_test();
    end
    // run needs about 500 cycles; 20000 means a hang
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
endmodule
